/* File: verilog/dpos_core.sv */
// DPLL control core: offset registers, step logic and loop filter.
// Assumes byte writes from the serial port logic and one system clock.
// Profile values and filter coefficients arrive as plain input levels.
`timescale 1ns/1ps
module dpos_core
(
	// Clock and reset
	input  wire logic               mclk_in,
	input  wire logic               reset_in,
	// Serial port register access
	input  wire logic        [15:0] reg_addr_in,
	input  wire logic        [7:0]  reg_wdata_in,
	input  wire logic               reg_wr_in,
	input  wire logic               reg_rd_in,
	output logic             [7:0]  reg_rdata_out,
	// Multifunction pin actions
	input  wire logic               mfp_en_in,
	input  wire logic               mfp_inc_in,
	input  wire logic               mfp_dec_in,
	input  wire logic               mfp_clr_in,
	// Profile values
	input  wire logic        [29:0] r_div_in,
	input  wire logic        [29:0] s_div_in,
	input  wire logic        [9:0]  u_num_in,
	input  wire logic        [9:0]  v_den_in,
	input  wire logic        [15:0] alpha_frac_in,
	input  wire logic        [3:0]  alpha_exp_in,
	input  wire logic        [2:0]  alpha_pexp0_in,
	input  wire logic        [2:0]  alpha_pexp1_in,
	input  wire logic        [15:0] beta_frac_in,
	input  wire logic        [3:0]  beta_exp_in,
	input  wire logic        [15:0] gamma_frac_in,
	input  wire logic        [3:0]  gamma_exp_in,
	input  wire logic        [15:0] delta_frac_in,
	input  wire logic        [3:0]  delta_exp_in,
	// Loop events
	input  wire logic               switching_in,
	input  wire logic               ref_edge_in,
	input  wire logic signed [39:0] ref_ts_in,
	input  wire logic               fb_roll_in,
	input  wire logic signed [39:0] fb_ts_in,
	// Status and tuning
	output logic signed      [39:0] applied_ofs_out,
	output logic signed      [39:0] incr_ofs_out,
	output logic                    slew_active_out,
	output logic                    tune_valid_out,
	output logic signed      [47:0] tune_word_out
);
	logic        [39:0] fixed_q;
	logic        [15:0] step_q;
	logic        [15:0] slew_q;
	logic signed [39:0] incr_q;
	logic signed [39:0] target;
	logic               ctrl_wr;
	logic               do_inc;
	logic               do_dec;
	logic               do_clr;
	logic signed [39:0] incr_base;
	logic signed [39:0] step_s;
	logic               pfd_valid;
	logic signed [47:0] pfd_err;
	logic               lf_valid;
	logic signed [47:0] lf_err;
	logic signed [47:0] integ_q;
	logic signed [47:0] lp1_q;
	logic signed [47:0] lp2_q;
	logic signed [47:0] prop;
	logic signed [47:0] stage0;
	logic signed [39:0] incr_d;
	logic        [7:0]  rd_byte_d;
	logic signed [47:0] integ_d;
	logic signed [47:0] lp1_d;
	logic signed [47:0] lp2_d;

	// ************************************************************
	// Decode helpers
	// ************************************************************
	function automatic logic in_range(input logic [15:0] a,
	                                  input logic [15:0] base,
	                                  input int          n);
		in_range = (a >= base) && ({16'h0, a} < {16'h0, base} + n);
	endfunction : in_range

	function automatic logic byte_hit(input logic [15:0] a,
	                                  input logic [15:0] base,
	                                  input int          i);
		byte_hit = (a == base + 16'(i));
	endfunction : byte_hit

	function automatic logic signed [47:0] coef(
		input logic signed [47:0] v,
		input logic        [15:0] frac,
		input logic        [3:0]  nexp,
		input logic        [3:0]  pexp);
		logic signed [64:0] p;
		p    = 65'(v) * $signed({1'b0, frac});
		p    = p >>> 16;
		p    = p <<< pexp;
		coef = 48'(p >>> nexp);
	endfunction : coef

	// ************************************************************
	// Configuration registers
	// ************************************************************
	always_ff @(posedge mclk_in)
	begin
		if (reset_in)
			fixed_q <= dpos_pkg::FIXED_RST;
		else if (reg_wr_in &&
		         in_range(reg_addr_in, dpos_pkg::ADDR_FIXED_OFS,
		                  dpos_pkg::FIXED_BYTES))
			for (int i = 0; i < dpos_pkg::FIXED_BYTES; i++)
				if (reg_addr_in == dpos_pkg::ADDR_FIXED_OFS + 16'(i))
					fixed_q[8*i +: 8] <= reg_wdata_in;
	end

	always_ff @(posedge mclk_in)
	begin
		if (reset_in)
			step_q <= dpos_pkg::STEP_RST;
		else if (reg_wr_in)
			for (int i = 0; i < dpos_pkg::HALF_BYTES; i++)
				if (byte_hit(reg_addr_in, dpos_pkg::ADDR_STEP, i))
					step_q[8*i +: 8] <= reg_wdata_in;
	end

	always_ff @(posedge mclk_in)
	begin
		if (reset_in)
			slew_q <= dpos_pkg::SLEW_RST;
		else if (reg_wr_in)
			for (int i = 0; i < dpos_pkg::HALF_BYTES; i++)
				if (byte_hit(reg_addr_in, dpos_pkg::ADDR_SLEW, i))
					slew_q[8*i +: 8] <= reg_wdata_in;
	end

	// ************************************************************
	// Readback; control bits read as zero
	// ************************************************************
	always_comb
	begin
		rd_byte_d = 8'h00;
		for (int i = 0; i < dpos_pkg::FIXED_BYTES; i++)
			if (byte_hit(reg_addr_in, dpos_pkg::ADDR_FIXED_OFS, i))
				rd_byte_d = fixed_q[8*i +: 8];
		for (int i = 0; i < dpos_pkg::HALF_BYTES; i++)
		begin
			if (byte_hit(reg_addr_in, dpos_pkg::ADDR_STEP, i))
				rd_byte_d = step_q[8*i +: 8];
			if (byte_hit(reg_addr_in, dpos_pkg::ADDR_SLEW, i))
				rd_byte_d = slew_q[8*i +: 8];
		end
	end

	always_ff @(posedge mclk_in)
	begin
		if (reset_in)
			reg_rdata_out <= 8'h00;
		else if (reg_rd_in)
			reg_rdata_out <= rd_byte_d;
	end

	// ************************************************************
	// Incremental offset actions; bits act once, never stored
	// ************************************************************
	assign ctrl_wr = reg_wr_in && (reg_addr_in == dpos_pkg::ADDR_CTRL);
	assign do_inc  = (ctrl_wr && reg_wdata_in[dpos_pkg::CTRL_INC_BIT]) ||
	                 (mfp_en_in && mfp_inc_in);
	assign do_dec  = (ctrl_wr && reg_wdata_in[dpos_pkg::CTRL_DEC_BIT]) ||
	                 (mfp_en_in && mfp_dec_in);
	assign do_clr  = (ctrl_wr && reg_wdata_in[dpos_pkg::CTRL_CLR_BIT]) ||
	                 (mfp_en_in && mfp_clr_in);
	assign incr_base = do_clr ? 40'sh0 : incr_q;
	assign step_s    = $signed({24'h0, step_q});

	always_comb
	begin
		if (do_inc && do_dec)
			incr_d = incr_base;
		else if (do_inc)
			incr_d = incr_base + step_s;
		else if (do_dec)
			incr_d = incr_base - step_s;
		else
			incr_d = incr_base;
	end

	always_ff @(posedge mclk_in)
	begin
		if (reset_in)
			incr_q <= 40'sh0;
		else
			incr_q <= incr_d;
	end

	assign incr_ofs_out = incr_q;
	assign target       = $signed(fixed_q) + incr_q;

	// ************************************************************
	// Offset slew limiter and detector
	// ************************************************************
	dpos_slew u_slew
	(
		.mclk_in       (mclk_in),
		.reset_in      (reset_in),
		.limit_in      (slew_q),
		.switching_in  (switching_in),
		.target_ofs_in (target),
		.err_valid_in  (pfd_valid),
		.err_in        (pfd_err),
		.ofs_out       (applied_ofs_out),
		.err_valid_out (lf_valid),
		.err_out       (lf_err),
		.active_out    (slew_active_out)
	);

	dpos_divpfd u_divpfd
	(
		.mclk_in       (mclk_in),
		.reset_in      (reset_in),
		.ref_edge_in   (ref_edge_in),
		.ref_ts_in     (ref_ts_in),
		.fb_roll_in    (fb_roll_in),
		.fb_ts_in      (fb_ts_in),
		.r_div_in      (r_div_in),
		.s_div_in      (s_div_in),
		.u_num_in      (u_num_in),
		.v_den_in      (v_den_in),
		.offset_in     (applied_ofs_out),
		.err_valid_out (pfd_valid),
		.err_out       (pfd_err)
	);

	// ************************************************************
	// Third order loop filter
	// ************************************************************
	assign prop   = coef(lf_err, alpha_frac_in, alpha_exp_in,
	                     4'(alpha_pexp0_in) + 4'(alpha_pexp1_in));
	assign stage0 = prop + integ_q;
	assign integ_d = integ_q + coef(lf_err, beta_frac_in, beta_exp_in,
	                                4'h0);
	assign lp1_d   = lp1_q + coef(stage0 - lp1_q, gamma_frac_in,
	                              gamma_exp_in, 4'h0);
	assign lp2_d   = lp2_q + coef(lp1_q - lp2_q, delta_frac_in,
	                              delta_exp_in, 4'h0);

	always_ff @(posedge mclk_in)
	begin
		if (reset_in)
		begin
			integ_q <= 48'sh0;
			lp1_q   <= 48'sh0;
			lp2_q   <= 48'sh0;
		end
		else if (lf_valid)
		begin
			integ_q <= integ_d;
			lp1_q   <= lp1_d;
			lp2_q   <= lp2_d;
		end
	end

	always_ff @(posedge mclk_in)
	begin
		if (reset_in)
		begin
			tune_valid_out <= 1'b0;
			tune_word_out  <= 48'sh0;
		end
		else
		begin
			tune_valid_out <= lf_valid;
			if (lf_valid)
				tune_word_out <= lp2_q;
		end
	end

endmodule : dpos_core

/* File: verilog/dpos_pkg.sv */
// Constants shared by the DPLL phase offset and slew control block.
// Assumes a 40 MHz system clock and byte-wide serial port register access.
package dpos_pkg;

	// ************************************************************
	// Register byte addresses (lowest address holds least byte)
	// ************************************************************
	localparam logic [15:0] ADDR_FIXED_OFS = 16'h030F;
	localparam logic [15:0] ADDR_STEP      = 16'h0314;
	localparam logic [15:0] ADDR_SLEW      = 16'h0316;
	localparam logic [15:0] ADDR_CTRL      = 16'h0A0C;
	localparam int          FIXED_BYTES    = 5;
	localparam int          HALF_BYTES     = 2;

	// ************************************************************
	// Control bit positions
	// ************************************************************
	localparam int CTRL_INC_BIT = 0;
	localparam int CTRL_DEC_BIT = 1;
	localparam int CTRL_CLR_BIT = 2;

	// ************************************************************
	// Widths and reset values
	// ************************************************************
	localparam int          OFS_W     = 40;
	localparam int          DAT_W     = 48;
	localparam int          DIV_W     = 30;
	localparam int          FRAC_W    = 10;
	localparam int          CF_W      = 16;
	localparam int          CE_W      = 4;
	localparam int          CP_W      = 3;
	localparam logic [39:0] FIXED_RST = 40'h00_0000_0000;
	localparam logic [15:0] STEP_RST  = 16'h0000;
	localparam logic [15:0] SLEW_RST  = 16'h0000;
	localparam logic [29:0] S_MIN     = 30'h0000_0007;

	// ************************************************************
	// Slew timing: limit is ns/s, offsets are ps
	// ************************************************************
	localparam int CLK_HZ    = 40_000_000;
	localparam int PS_PER_NS = 1000;
	localparam int SLEW_DIV  = CLK_HZ / PS_PER_NS;

endpackage : dpos_pkg

/* File: verilog/dpos_divpfd.sv */
// Reference prescaler, fractional feedback divider and digital PFD.
// Assumes edge pulses with picosecond timestamps from the TDC and DDS.
`timescale 1ns/1ps
module dpos_divpfd
(
	// Clock and reset
	input  wire logic               mclk_in,
	input  wire logic               reset_in,
	// Edges and timestamps
	input  wire logic               ref_edge_in,
	input  wire logic signed [39:0] ref_ts_in,
	input  wire logic               fb_roll_in,
	input  wire logic signed [39:0] fb_ts_in,
	// Division settings
	input  wire logic        [29:0] r_div_in,
	input  wire logic        [29:0] s_div_in,
	input  wire logic        [9:0]  u_num_in,
	input  wire logic        [9:0]  v_den_in,
	input  wire logic signed [39:0] offset_in,
	// Error output
	output logic                    err_valid_out,
	output logic signed      [47:0] err_out
);
	logic        [29:0] r_cnt_q;
	logic        [30:0] f_cnt_q;
	logic        [10:0] frac_q;
	logic               carry_q;
	logic signed [39:0] ref_word_q;
	logic signed [39:0] fb_word_q;
	logic               ref_seen_q;
	logic               fb_seen_q;
	logic               ref_tick;
	logic               fb_tick;
	logic               pair;
	logic        [29:0] s_eff;
	logic        [10:0] frac_sum;
	logic signed [47:0] pump;

	// ************************************************************
	// Dividers
	// ************************************************************
	assign ref_tick = ref_edge_in && (r_cnt_q >= r_div_in);
	assign s_eff    = (s_div_in < dpos_pkg::S_MIN) ? dpos_pkg::S_MIN
	                                               : s_div_in;
	assign fb_tick  = fb_roll_in &&
	                  (f_cnt_q >= ({1'b0, s_eff} + {30'h0, carry_q}));
	assign frac_sum = frac_q + {1'b0, u_num_in};

	always_ff @(posedge mclk_in)
	begin
		if (reset_in)
			r_cnt_q <= 30'h0;
		else if (ref_tick)
			r_cnt_q <= 30'h0;
		else if (ref_edge_in)
			r_cnt_q <= r_cnt_q + 30'h1;
	end

	always_ff @(posedge mclk_in)
	begin
		if (reset_in)
		begin
			f_cnt_q <= 31'h0;
			frac_q  <= 11'h0;
			carry_q <= 1'b0;
		end
		else if (fb_tick)
		begin
			f_cnt_q <= 31'h0;
			// Fraction adds one extra rollover U times in V
			if (v_den_in != 10'h0 && frac_sum >= {1'b0, v_den_in})
			begin
				frac_q  <= frac_sum - {1'b0, v_den_in};
				carry_q <= 1'b1;
			end
			else
			begin
				frac_q  <= (v_den_in == 10'h0) ? 11'h0 : frac_sum;
				carry_q <= 1'b0;
			end
		end
		else if (fb_roll_in)
			f_cnt_q <= f_cnt_q + 31'h1;
	end

	// ************************************************************
	// Phase detector: code pump into integrator
	// ************************************************************
	assign pair = ref_seen_q && fb_seen_q;
	assign pump = 48'(ref_word_q) - 48'(fb_word_q)
	            - 48'(offset_in);

	always_ff @(posedge mclk_in)
	begin
		if (reset_in)
		begin
			ref_word_q <= 40'sh0;
			fb_word_q  <= 40'sh0;
			ref_seen_q <= 1'b0;
			fb_seen_q  <= 1'b0;
		end
		else
		begin
			if (ref_tick)
				ref_word_q <= ref_ts_in;
			if (fb_tick)
				fb_word_q <= fb_ts_in;
			ref_seen_q <= ref_tick || (ref_seen_q && !pair);
			fb_seen_q  <= fb_tick || (fb_seen_q && !pair);
		end
	end

	always_ff @(posedge mclk_in)
	begin
		if (reset_in)
		begin
			err_out       <= 48'sh0;
			err_valid_out <= 1'b0;
		end
		else
		begin
			err_valid_out <= pair;
			if (pair)
				err_out <= err_out + pump;
		end
	end

endmodule : dpos_divpfd

/* File: verilog/dpos_slew.sv */
// Phase slew rate limiter for offsets and the detector error.
// Assumes limit in ns/s and a 40 MHz clock; zero limit bypasses it.
`timescale 1ns/1ps
module dpos_slew
(
	// Clock and reset
	input  wire logic               mclk_in,
	input  wire logic               reset_in,
	// Control
	input  wire logic        [15:0] limit_in,
	input  wire logic               switching_in,
	input  wire logic signed [39:0] target_ofs_in,
	// Detector error in
	input  wire logic               err_valid_in,
	input  wire logic signed [47:0] err_in,
	// Limited outputs
	output logic signed      [39:0] ofs_out,
	output logic                    err_valid_out,
	output logic signed      [47:0] err_out,
	output logic                    active_out
);
	localparam logic [31:0] DIV = 32'(dpos_pkg::SLEW_DIV);

	logic        [31:0] acc_q;
	logic        [31:0] budget_q;
	logic        [31:0] sum;
	logic        [1:0]  grant;
	logic signed [47:0] diff;
	logic signed [47:0] lim;
	logic signed [39:0] odiff;

	assign active_out = (limit_in != 16'h0);

	// ************************************************************
	// Credit generator: limit*1000 ps per second
	// ************************************************************
	assign sum   = acc_q + {16'h0, limit_in};
	assign grant = (sum >= (DIV << 1)) ? 2'h2 : (sum >= DIV) ? 2'h1 : 2'h0;

	always_ff @(posedge mclk_in)
	begin
		if (reset_in || !active_out)
			acc_q <= 32'h0;
		else
			acc_q <= sum - (DIV * {30'h0, grant});
	end

	// ************************************************************
	// Offset tracking
	// ************************************************************
	assign odiff = target_ofs_in - ofs_out;

	always_ff @(posedge mclk_in)
	begin
		if (reset_in)
			ofs_out <= 40'sh0;
		else if (!active_out)
			ofs_out <= target_ofs_in;
		else if (odiff > 40'sh0)
			ofs_out <= ofs_out + ((odiff > 40'sh1 && grant == 2'h2)
			           ? 40'sh2 : (grant != 2'h0 ? 40'sh1 : 40'sh0));
		else if (odiff < 40'sh0)
			ofs_out <= ofs_out - ((odiff < -40'sh1 && grant == 2'h2)
			           ? 40'sh2 : (grant != 2'h0 ? 40'sh1 : 40'sh0));
	end

	// ************************************************************
	// Error limiting during switchover
	// ************************************************************
	assign diff = err_in - err_out;
	assign lim  = 48'(budget_q);

	always_ff @(posedge mclk_in)
	begin
		if (reset_in)
			budget_q <= 32'h0;
		else if (err_valid_in)
			budget_q <= {30'h0, grant};
		else if (budget_q < 32'hFFFF_FFF0)
			budget_q <= budget_q + {30'h0, grant};
	end

	always_ff @(posedge mclk_in)
	begin
		if (reset_in)
		begin
			err_out       <= 48'sh0;
			err_valid_out <= 1'b0;
		end
		else
		begin
			err_valid_out <= err_valid_in;
			if (err_valid_in)
			begin
				if (!active_out || !switching_in)
					err_out <= err_in;
				else if (diff > lim)
					err_out <= err_out + lim;
				else if (diff < -lim)
					err_out <= err_out - lim;
				else
					err_out <= err_in;
			end
		end
	end

endmodule : dpos_slew

/* File: tb/dpos_core_sva.sv */
// Assertions on offset stepping, readback and slew ports of dpos_core.
// Bound to every dpos_core instance; sees its ports only.
`timescale 1ns/1ps
module dpos_core_sva
(
	// Clock and reset
	input wire logic               mclk_in,
	input wire logic               reset_in,
	// Register port
	input wire logic        [15:0] reg_addr_in,
	input wire logic        [7:0]  reg_wdata_in,
	input wire logic               reg_wr_in,
	input wire logic               reg_rd_in,
	input wire logic        [7:0]  reg_rdata_out,
	// Pins
	input wire logic               mfp_en_in,
	input wire logic               mfp_inc_in,
	input wire logic               mfp_dec_in,
	input wire logic               mfp_clr_in,
	// Status
	input wire logic signed [39:0] applied_ofs_out,
	input wire logic signed [39:0] incr_ofs_out,
	input wire logic               slew_active_out,
	input wire logic               tune_valid_out
);
	// ********************
	// Shadow registers
	// ********************
	logic [15:0] step_q;
	logic [15:0] slew_q;
	logic        cw;
	logic        inc;
	logic        dec;
	logic        clr;
	assign cw  = reg_wr_in && reg_addr_in == dpos_pkg::ADDR_CTRL;
	assign inc = cw && reg_wdata_in[0] || mfp_en_in && mfp_inc_in;
	assign dec = cw && reg_wdata_in[1] || mfp_en_in && mfp_dec_in;
	assign clr = cw && reg_wdata_in[2] || mfp_en_in && mfp_clr_in;
	always_ff @(posedge mclk_in)
	begin
		if (reset_in)
		begin
			step_q <= 16'h0000;
			slew_q <= 16'h0000;
		end
		else if (reg_wr_in && reg_addr_in[15:1] == 15'h018A)
			step_q[{reg_addr_in[0], 3'h0} +: 8] <= reg_wdata_in;
		else if (reg_wr_in && reg_addr_in[15:1] == 15'h018B)
			slew_q[{reg_addr_in[0], 3'h0} +: 8] <= reg_wdata_in;
	end
	// ********************
	// Properties
	// ********************
	default clocking cb @(posedge mclk_in);
	endclocking
	default disable iff (reset_in);
	a_inc_adds_step: assert property
		(inc && !dec && !clr |=>
		 incr_ofs_out == $past(incr_ofs_out) + $past(step_q))
		else $error("increment result wrong");
	a_dec_subs_step: assert property
		(dec && !inc && !clr |=>
		 incr_ofs_out == $past(incr_ofs_out) - $past(step_q))
		else $error("decrement result wrong");
	a_both_cancel: assert property
		(inc && dec && !clr |=> $stable(incr_ofs_out))
		else $error("increment with decrement moved offset");
	a_clear_zeroes: assert property
		(clr && !inc && !dec |=> incr_ofs_out == 40'sh00_0000_0000)
		else $error("clear left offset");
	a_idle_holds: assert property
		(!inc && !dec && !clr |=> $stable(incr_ofs_out))
		else $error("offset moved without action");
	a_step_readback: assert property
		(reg_rd_in && reg_addr_in[15:1] == 15'h018A |=> reg_rdata_out ==
		 ($past(reg_addr_in[0]) ? $past(step_q[15:8]) : $past(step_q[7:0])))
		else $error("step readback wrong");
	a_slew_zero_off: assert property
		(slew_active_out == (slew_q != 16'h0000))
		else $error("slew active flag wrong");
	a_slew_rate_cap: assert property
		(slew_active_out && $past(slew_active_out) &&
		 $past(slew_active_out, 2) |->
		 $unsigned(40'(applied_ofs_out - $past(applied_ofs_out) + 40'sh2))
		 <= 40'h00_0000_0004)
		else $error("offset slewed too fast");
	c_both_steps: cover property (inc && dec);
	c_slewing: cover property (slew_active_out && $changed(applied_ofs_out));
	c_tune: cover property (tune_valid_out);
endmodule : dpos_core_sva

bind dpos_core dpos_core_sva u_sva
(
	.mclk_in, .reset_in, .reg_addr_in, .reg_wdata_in, .reg_wr_in,
	.reg_rd_in, .reg_rdata_out, .mfp_en_in, .mfp_inc_in, .mfp_dec_in,
	.mfp_clr_in, .applied_ofs_out, .incr_ofs_out, .slew_active_out,
	.tune_valid_out
);

/* File: tb/dpos_ref_model.sv */
// Reference edge and feedback rollover source for the core.
// Assumes the core takes edges and timestamps on mclk_in rising.
`timescale 1ns/1ps
module dpos_ref_model
#(
	parameter logic signed [39:0] TS = 40'sh00_0000_61A8
)
(
	// Clock and reset
	input  wire logic               mclk_in,
	input  wire logic               reset_in,
	// Control
	input  wire logic               run_in,
	// Edges
	output logic                    ref_edge_out,
	output logic signed      [39:0] ref_ts_out,
	output logic                    fb_roll_out,
	output logic signed      [39:0] fb_ts_out
);
	// Stamps are only meaningful with a pulse; otherwise they toggle
	always_ff @(posedge mclk_in)
	begin
		if (reset_in)
		begin
			ref_edge_out <= 1'b0;
			fb_roll_out  <= 1'b0;
			ref_ts_out   <= 40'sh00_0000_0000;
			fb_ts_out    <= 40'sh00_0000_0000;
		end
		else
		begin
			ref_edge_out <= run_in;
			fb_roll_out  <= run_in;
			ref_ts_out   <= run_in ? TS : ~ref_ts_out;
			fb_ts_out    <= run_in ? TS : ~fb_ts_out;
		end
	end
endmodule : dpos_ref_model

/* File: tb/dpos_core_test.sv */
// Self-checking bench for the DPLL offset and slew control core.
// Assumes the edge source model and the bound checker are compiled.
`timescale 1ns/1ps
module dpos_core_test;
	// ********************
	// Signals
	// ********************
	logic               mclk_in = 1'b0;
	logic               reset_in = 1'b1;
	logic        [15:0] reg_addr_in = 16'h0000;
	logic        [7:0]  reg_wdata_in = 8'h00;
	logic               reg_wr_in = 1'b0, reg_rd_in = 1'b0;
	logic               mfp_en_in = 1'b0, mfp_inc_in = 1'b0;
	logic               mfp_dec_in = 1'b0, mfp_clr_in = 1'b0;
	logic        [29:0] r_div_in = 30'h0, s_div_in = 30'h7;
	logic        [9:0]  u_num_in = 10'h0, v_den_in = 10'h0;
	logic        [15:0] alpha_frac_in = 16'h8000, beta_frac_in = 16'h4000;
	logic        [15:0] gamma_frac_in = 16'h4000, delta_frac_in = 16'h4000;
	logic        [3:0]  alpha_exp_in = 4'h1, beta_exp_in = 4'h4;
	logic        [3:0]  gamma_exp_in = 4'h2, delta_exp_in = 4'h2;
	logic        [2:0]  alpha_pexp0_in = 3'h1, alpha_pexp1_in = 3'h1;
	logic               switching_in = 1'b0, run = 1'b0;
	logic               ref_edge_in, fb_roll_in, tune_valid_out;
	logic               slew_active_out;
	logic signed [39:0] ref_ts_in, fb_ts_in, applied_ofs_out, incr_ofs_out;
	logic signed [47:0] tune_word_out;
	logic        [7:0]  reg_rdata_out;
	logic        [39:0] fx;
	int                 mismatches = 0, check_count = 0, n;

	always #12.5 mclk_in = ~mclk_in;

	dpos_core dut
	(
		.mclk_in, .reset_in, .reg_addr_in, .reg_wdata_in, .reg_wr_in,
		.reg_rd_in, .reg_rdata_out, .mfp_en_in, .mfp_inc_in, .mfp_dec_in,
		.mfp_clr_in, .r_div_in, .s_div_in, .u_num_in, .v_den_in,
		.alpha_frac_in, .alpha_exp_in, .alpha_pexp0_in, .alpha_pexp1_in,
		.beta_frac_in, .beta_exp_in, .gamma_frac_in, .gamma_exp_in,
		.delta_frac_in, .delta_exp_in, .switching_in, .ref_edge_in,
		.ref_ts_in, .fb_roll_in, .fb_ts_in, .applied_ofs_out,
		.incr_ofs_out, .slew_active_out, .tune_valid_out, .tune_word_out
	);
	dpos_ref_model u_ref
	(
		.mclk_in, .reset_in, .run_in(run), .ref_edge_out(ref_edge_in),
		.ref_ts_out(ref_ts_in), .fb_roll_out(fb_roll_in),
		.fb_ts_out(fb_ts_in)
	);

	// ********************
	// Tasks
	// ********************
	task automatic check(input logic [39:0] seen, input logic [39:0] exp);
		check_count++;
		if (seen !== exp)
		begin
			mismatches++;
			$display("BAD at %0t seen %h expected %h", $time, seen, exp);
		end
	endtask : check

	task automatic wr(input logic [15:0] a, input logic [7:0] d);
		@(posedge mclk_in);
		reg_addr_in  <= a;
		reg_wdata_in <= d;
		reg_wr_in    <= 1'b1;
		@(posedge mclk_in);
		reg_wr_in    <= 1'b0;
	endtask : wr

	task automatic rd(input logic [15:0] a, input logic [7:0] e);
		@(posedge mclk_in);
		reg_addr_in <= a;
		reg_rd_in   <= 1'b1;
		@(posedge mclk_in);
		reg_rd_in   <= 1'b0;
		#1;
		check({32'h0, reg_rdata_out}, {32'h0, e});
	endtask : rd

	task automatic act(input logic [7:0] d, input logic [39:0] e);
		wr(dpos_pkg::ADDR_CTRL, d);
		#1;
		check(incr_ofs_out, e);
	endtask : act

	task automatic pin(input logic [2:0] p, input logic [39:0] e);
		@(posedge mclk_in);
		{mfp_clr_in, mfp_dec_in, mfp_inc_in} <= p;
		@(posedge mclk_in);
		{mfp_clr_in, mfp_dec_in, mfp_inc_in} <= 3'h0;
		#1;
		check(incr_ofs_out, e);
	endtask : pin

	// Counts loop outputs over a fixed window for one divider setting
	task automatic lc(input logic [29:0] r, input logic [29:0] s,
		input logic [9:0] u, input logic [9:0] v, input int e);
		int c;
		c = 0;
		@(posedge mclk_in);
		r_div_in <= r;
		s_div_in <= s;
		u_num_in <= u;
		v_den_in <= v;
		repeat (40) @(posedge mclk_in);
		repeat (720)
		begin
			@(posedge mclk_in);
			#1;
			c += int'(tune_valid_out);
		end
		check(40'(c > e - 4 && c < e + 4), 40'h1);
	endtask : lc

	task automatic finish_test;
		$display("Comparisons %0d mismatches %0d", check_count, mismatches);
		if (mismatches == 0 && check_count > 0)
			$display("No errors found");
		else
			$display("Errors were found");
		$finish;
	endtask : finish_test

	// ********************
	// Sequence
	// ********************
	initial
	begin
		repeat (12) @(posedge mclk_in);
		reset_in <= 1'b0;
		run      <= 1'b1;
		lc(30'h3, 30'h7, 10'h0, 10'h0, 90);
		check(40'(tune_word_out === 48'h0), 40'h1);
		lc(30'hF, 30'h7, 10'h0, 10'h0, 45);
		lc(30'h0, 30'h7, 10'h1, 10'h2, 85);
		lc(30'h3, 30'h0, 10'h0, 10'h0, 90);
		rd(16'h0316, 8'h00);
		rd(16'h0317, 8'h00);
		rd(16'h0318, 8'h00);
		check(40'(slew_active_out), 40'h0);
		fx = 40'hFF_FFFF_FC18;
		for (n = 0; n < 5; n++)
			wr(16'h030F + 16'(n), fx[8 * n +: 8]);
		for (n = 0; n < 5; n++)
			rd(16'h030F + 16'(n), fx[8 * n +: 8]);
		wr(16'h0314, 8'h23);
		wr(16'h0315, 8'h01);
		rd(16'h0314, 8'h23);
		rd(16'h0315, 8'h01);
		act(8'h01, 40'h00_0000_0123);
		act(8'h01, 40'h00_0000_0246);
		act(8'h02, 40'h00_0000_0123);
		act(8'h03, 40'h00_0000_0123);
		act(8'h04, 40'h00_0000_0000);
		act(8'h02, 40'hFF_FFFF_FEDD);
		rd(dpos_pkg::ADDR_CTRL, 8'h00);
		check(incr_ofs_out, 40'hFF_FFFF_FEDD);
		act(8'h05, 40'h00_0000_0123);
		repeat (4) @(posedge mclk_in);
		#1;
		check(applied_ofs_out, fx + 40'h00_0000_0123);
		check(40'(tune_word_out !== 48'h0), 40'h1);
		pin(3'h1, 40'h00_0000_0123);
		@(posedge mclk_in);
		mfp_en_in <= 1'b1;
		pin(3'h2, 40'h00_0000_0000);
		pin(3'h1, 40'h00_0000_0123);
		pin(3'h4, 40'h00_0000_0000);
		wr(16'h0316, 8'hFF);
		wr(16'h0317, 8'hFF);
		#1;
		check(40'(slew_active_out), 40'h1);
		@(posedge mclk_in);
		switching_in <= 1'b1;
		wr(16'h0313, 8'h00);
		#1;
		fx = applied_ofs_out;
		repeat (400) @(posedge mclk_in);
		#1;
		fx = applied_ofs_out - fx;
		check(40'(fx > 40'h285 && fx < 40'h299), 40'h1);
		finish_test();
	end
endmodule : dpos_core_test
